// ### logic/sensor_cfg_map.svh
// Register map, field positions and reset values of the sensor setup bank.
// Assumes a 32-bit AXI4-Lite slave; each register sits in one aligned word.
`ifndef SENSOR_CFG_MAP_SVH
`define SENSOR_CFG_MAP_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define IDX_COUNTER_SCALE   6'h1E
`define IDX_CH0_SETUP       6'h20
`define IDX_CH1_SETUP       6'h22
`define IDX_CH2_SETUP       6'h24
`define IDX_CH0_FAST_TRACK  6'h25
`define IDX_CH3_SETUP       6'h26

// ============================================================
// Reset values
`define RST_COUNTER_SCALE   8'h55
`define RST_SENSOR_SETUP    8'h04
`define RST_FAST_TRACK      8'hDA

// ============================================================
// Field positions
`define SETUP_RANGE_BIT     7
`define SETUP_BAND_HI       6
`define SETUP_BAND_LO       5
`define SETUP_CYC_HI        4
`define SETUP_CYC_LO        0
`define SCALE_W             2
`define NUM_CH              4

// ============================================================
// Bus widths and responses
`define ADDR_W              8
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### logic/sensor_cfg_pkg.sv
// Types shared by the sensor setup register bank.
// Assumes sensor_cfg_map.svh supplies the widths.
`include "sensor_cfg_map.svh"

package sensor_cfg_pkg;

    // ============================================================
    // Whole state of the register bank
    typedef struct packed {
        logic                    aw_have;
        logic [5:0]              aw_idx;
        logic                    aw_bad;
        logic                    w_have;
        logic [7:0]              w_data;
        logic                    w_lane0;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [7:0]              rdata;
        logic [7:0]              scale;
        logic [`NUM_CH-1:0][7:0] setup;
        logic [7:0]              fast_track;
        logic [7:0]              act_scale;
        logic [`NUM_CH-1:0][7:0] act_setup;
    } bank_state_s;

endpackage : sensor_cfg_pkg

// ### logic/sensor_channel_config_regs.sv
// Per-channel sensor front-end setup registers behind an AXI4-Lite slave.
// Assumes one clock; conv_start pulses come from the conversion engine
// on the same clock and need no synchroniser.
`timescale 1ns/1ns
`include "sensor_cfg_map.svh"

// Contract
// - Four 2-bit scale fields, each resetting one
// - Setup bit 7 picks resistance range, default low
// - Bits 6-5 pick frequency band, reset zero
// - Bits 4-0 hold cycle count, reset four
// - Channel 0-2 setup at 0x20/0x22/0x24, reset 0x04
// - Fast track register at 0x25, reset 0xDA
// - Scale register at 0x1E, reset 0x55
// - Channel 3 setup at 0x26, same layout
module sensor_channel_config_regs (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 awaddr,
    input  wire logic [2:0]                  awprot,
    // AXI4-Lite write data
    input  wire logic                        wvalid,
    output logic                             wready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    // AXI4-Lite write response
    output logic                             bvalid,
    input  wire logic                        bready,
    output logic [1:0]                       bresp,
    // AXI4-Lite read address
    input  wire logic                        arvalid,
    output logic                             arready,
    input  wire logic [31:0]                 araddr,
    input  wire logic [2:0]                  arprot,
    // AXI4-Lite read data
    output logic                             rvalid,
    input  wire logic                        rready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    // Conversion engine
    input  wire logic [`NUM_CH-1:0]          conv_start,
    output logic [`NUM_CH-1:0]               resistance_range,
    output logic [`NUM_CH-1:0][1:0]          band_select,
    output logic [`NUM_CH-1:0][4:0]          cycle_count,
    output logic [`NUM_CH-1:0][`SCALE_W-1:0] count_scale,
    output logic [7:0]                       ch0_fast_track
);
    import sensor_cfg_pkg::*;

    bank_state_s state;
    bank_state_s next_state;

    // ============================================================
    // Address decode
    // Upper address bits must be zero, so no address above 0xFF aliases a register; the low two bits are ignored
    function automatic logic addr_bad(input logic [31:0] addr);
        addr_bad = (addr[31:`ADDR_W] != 24'h00_0000)
                   || !(addr[7:2] == `IDX_COUNTER_SCALE
                        || addr[7:2] == `IDX_CH0_SETUP
                        || addr[7:2] == `IDX_CH1_SETUP
                        || addr[7:2] == `IDX_CH2_SETUP
                        || addr[7:2] == `IDX_CH0_FAST_TRACK
                        || addr[7:2] == `IDX_CH3_SETUP);
    endfunction : addr_bad

    // Read mux; unmapped words read zero
    function automatic logic [7:0] read_word(input logic [5:0] idx, input bank_state_s s);
        case (idx)
            `IDX_COUNTER_SCALE:  read_word = s.scale;
            `IDX_CH0_SETUP:      read_word = s.setup[0];
            `IDX_CH1_SETUP:      read_word = s.setup[1];
            `IDX_CH2_SETUP:      read_word = s.setup[2];
            `IDX_CH0_FAST_TRACK: read_word = s.fast_track;
            `IDX_CH3_SETUP:      read_word = s.setup[3];
            default:             read_word = 8'h00;
        endcase
    endfunction : read_word

    // ============================================================
    // Handshake outputs
    // One item of each kind held at a time keeps the slave simple
    assign awready = !state.aw_have;
    assign wready  = !state.w_have;
    assign arready = !state.rvalid;
    assign bvalid  = state.bvalid;
    assign bresp   = state.bresp;
    assign rvalid  = state.rvalid;
    assign rresp   = state.rresp;
    assign rdata   = {24'h00_0000, state.rdata};

    logic commit;
    assign commit = state.aw_have && state.w_have && !state.bvalid;

    // ============================================================
    // Next-state logic
    always_comb
    begin
        next_state = state;
        // Address and data are taken in either order
        if (awvalid && awready)
        begin
            next_state.aw_have = 1'b1;
            next_state.aw_idx  = awaddr[7:2];
            next_state.aw_bad  = addr_bad(awaddr);
        end
        if (wvalid && wready)
        begin
            next_state.w_have  = 1'b1;
            next_state.w_data  = wdata[7:0];
            next_state.w_lane0 = wstrb[0];
        end
        if (state.bvalid && bready)
        begin
            next_state.bvalid = 1'b0;
        end
        // Register update once both halves are present
        if (commit)
        begin
            next_state.aw_have = 1'b0;
            next_state.w_have  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = state.aw_bad ? `RESP_SLVERR : `RESP_OKAY;
            // Only byte lane 0 carries register bits
            if (!state.aw_bad && state.w_lane0)
            begin
                case (state.aw_idx)
                    `IDX_COUNTER_SCALE:  next_state.scale      = state.w_data;
                    `IDX_CH0_SETUP:      next_state.setup[0]   = state.w_data;
                    `IDX_CH1_SETUP:      next_state.setup[1]   = state.w_data;
                    `IDX_CH2_SETUP:      next_state.setup[2]   = state.w_data;
                    `IDX_CH0_FAST_TRACK: next_state.fast_track = state.w_data;
                    `IDX_CH3_SETUP:      next_state.setup[3]   = state.w_data;
                    default:             next_state.scale      = state.scale;
                endcase
            end
        end
        // Read answer the cycle after the address is taken
        if (state.rvalid && rready)
        begin
            next_state.rvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = addr_bad(araddr) ? `RESP_SLVERR : `RESP_OKAY;
            next_state.rdata  = addr_bad(araddr) ? 8'h00 : read_word(araddr[7:2], state);
        end
        // Shadow copies load only at a conversion start, so a setup or scale write
        // landing mid-conversion never disturbs the running one; fast track is not shadowed
        for (int ch = 0; ch < `NUM_CH; ch++)
        begin
            if (conv_start[ch])
            begin
                next_state.act_setup[ch] = next_state.setup[ch];
                next_state.act_scale[ch*`SCALE_W +: `SCALE_W] =
                    next_state.scale[ch*`SCALE_W +: `SCALE_W];
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state            <= '0;
            state.scale      <= `RST_COUNTER_SCALE;
            state.setup      <= {`NUM_CH{`RST_SENSOR_SETUP}};
            state.fast_track <= `RST_FAST_TRACK;
            state.act_scale  <= `RST_COUNTER_SCALE;
            state.act_setup  <= {`NUM_CH{`RST_SENSOR_SETUP}};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ============================================================
    // Per-channel settings to the conversion engine
    // Band code three is passed as written; software must avoid it
    for (genvar ch = 0; ch < `NUM_CH; ch++)
    begin : g_chan
        assign resistance_range[ch] = state.act_setup[ch][`SETUP_RANGE_BIT];
        assign band_select[ch] =
            state.act_setup[ch][`SETUP_BAND_HI:`SETUP_BAND_LO];
        assign cycle_count[ch] =
            state.act_setup[ch][`SETUP_CYC_HI:`SETUP_CYC_LO];
        assign count_scale[ch] =
            state.act_scale[ch*`SCALE_W +: `SCALE_W];
    end
    assign ch0_fast_track = state.fast_track;

    // ============================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_resp_seen;
        bvalid ##1 1'b1;
    endsequence

    AST_RESET_VALUES: assert property ($past(!aresetn) |->
        state.scale == 8'h55 && state.setup[2] == 8'h04 && state.fast_track == 8'hDA)
        else $error("reset values wrong");

    AST_WRITE_RESP: assert property (s_write_taken |-> ##[1:4] s_resp_seen)
        else $error("write response missing");

    AST_WRITE_CH0: assert property (commit && state.w_lane0
        && state.aw_idx == 6'h20 && !state.aw_bad |=> state.setup[0] == $past(state.w_data))
        else $error("channel 0 setup not written");

    AST_WRITE_CH3: assert property (commit && state.w_lane0
        && state.aw_idx == 6'h26 && !state.aw_bad |=> state.setup[3] == $past(state.w_data))
        else $error("channel 3 setup not written");

    AST_READ_FAST: assert property (arvalid && arready
        && araddr == 32'h0000_0094 |=> rvalid && rdata[7:0] == $past(state.fast_track))
        else $error("fast track read wrong");

    AST_HOLD_MIDCONV: assert property (!conv_start[0] |=> $stable(cycle_count[0]))
        else $error("setting changed mid conversion");

    AST_RANGE_LOAD: assert property (conv_start[2] |=>
        resistance_range[2] == $past(next_state.setup[2][7]))
        else $error("range not loaded");

    AST_BAND_LOAD: assert property (conv_start[1] |=>
        band_select[1] == $past(next_state.setup[1][6:5]))
        else $error("band not loaded");

    AST_SCALE_LOAD: assert property (conv_start[3] |=>
        count_scale[3] == $past(next_state.scale[7:6]))
        else $error("scale not loaded");

    AST_UNMAPPED_ZERO: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule : sensor_channel_config_regs

// ### bench/tb_top.sv
// Self-checking bench for the sensor setup register bank.
// Assumes the bank's AXI4-Lite slave and the shared map header; no partner model.
`timescale 1ns/1ns
`include "sensor_cfg_map.svh"

module tb_top;
    import sensor_cfg_pkg::*;

    // ============================================================
    // Signals
    logic                          aclk, aresetn;
    logic                          awvalid, awready, wvalid, wready, bvalid, bready;
    logic                          arvalid, arready, rvalid, rready;
    logic [31:0]                   awaddr, wdata, araddr, rdata;
    logic [2:0]                    awprot, arprot;
    logic [3:0]                    wstrb;
    logic [1:0]                    bresp, rresp;
    logic [`NUM_CH-1:0]            conv_start, resistance_range;
    logic [`NUM_CH-1:0][1:0]       band_select, count_scale;
    logic [`NUM_CH-1:0][4:0]       cycle_count;
    logic [7:0]                    ch0_fast_track;
    int                            miscompares, n_compared;
    logic [31:0]                   addr_tab [6];
    logic [7:0]                    rst_tab  [6];
    logic [7:0]                    val_tab  [6];
    int                            sidx     [4];

    sensor_channel_config_regs sensor_channel_config_regs_i (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .conv_start(conv_start), .resistance_range(resistance_range),
        .band_select(band_select), .cycle_count(cycle_count),
        .count_scale(count_scale), .ch0_fast_track(ch0_fast_track)
    );

    // ============================================================
    // Clock, 100 ns period
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ============================================================
    // Checking and closing
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ============================================================
    // Bus tasks; no wait has its own time limit, so only the watchdog ends a hung wait
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_left;
        logic w_left;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {24'h00_0000, d};
        wstrb <= s; bready <= 1'b1;
        aw_left = 1'b1;
        w_left = 1'b1;
        while (aw_left || w_left)
        begin
            @(posedge aclk);
            if (aw_left && awready) begin aw_left = 1'b0; awvalid <= 1'b0; end
            if (w_left && wready) begin w_left = 1'b0; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rd

    // One-cycle start pulse; outputs settle one edge later
    task automatic pulse(input logic [3:0] m);
        @(posedge aclk);
        conv_start <= m;
        @(posedge aclk);
        conv_start <= 4'h0;
        @(posedge aclk);
        #1;
    endtask : pulse

    // Shadow outputs of one channel against stored setup and scale bytes
    task automatic chk_out(input int c, input logic [7:0] st, input logic [7:0] sc);
        chk("range", {31'h0, st[7]}, {31'h0, resistance_range[c]});
        chk("band", {30'h0, st[6:5]}, {30'h0, band_select[c]});
        chk("cycles", {27'h0, st[4:0]}, {27'h0, cycle_count[c]});
        chk("scale", {30'h0, sc[2*c +: 2]}, {30'h0, count_scale[c]});
    endtask : chk_out

    // ============================================================
    // Watchdog at 3000 cycles, far beyond the hundred or so cycles the tests need
    initial
    begin
        #(3000 * 100);
        miscompares++;
        complete_run();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0; wstrb = 4'h0;
        awprot = 3'h0; arprot = 3'h0; conv_start = 4'h0;
        miscompares = 0; n_compared = 0;
        // Order: scale, ch0, ch1, ch2, fast track, ch3
        addr_tab = '{32'(`IDX_COUNTER_SCALE) << 2, 32'(`IDX_CH0_SETUP) << 2,
                     32'(`IDX_CH1_SETUP) << 2, 32'(`IDX_CH2_SETUP) << 2,
                     32'(`IDX_CH0_FAST_TRACK) << 2, 32'(`IDX_CH3_SETUP) << 2};
        rst_tab = '{8'h55, 8'h04, 8'h04, 8'h04, 8'hDA, 8'h04};
        // Every scale code, every legal band, cycle count extremes
        val_tab = '{8'hE4, 8'h9F, 8'h20, 8'hC5, 8'h3C, 8'h4A};
        sidx = '{1, 2, 3, 5};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values
        for (int i = 0; i < 6; i++) rd(addr_tab[i], {24'h0, rst_tab[i]}, 2'h0);
        for (int c = 0; c < 4; c++) chk_out(c, 8'h04, 8'h55);
        chk("fast_track", 32'hDA, {24'h0, ch0_fast_track});
        // Write and read back every register
        for (int i = 0; i < 6; i++) wr(addr_tab[i], val_tab[i], 4'hF, 2'h0);
        for (int i = 0; i < 6; i++) rd(addr_tab[i], {24'h0, val_tab[i]}, 2'h0);
        chk("fast_track", 32'h3C, {24'h0, ch0_fast_track});
        // No start yet, so outputs keep reset settings
        for (int c = 0; c < 4; c++) chk_out(c, 8'h04, 8'h55);
        pulse(4'hF);
        for (int c = 0; c < 4; c++) chk_out(c, val_tab[sidx[c]], val_tab[0]);
        // Start on another channel must not load channel 0
        wr(addr_tab[1], 8'h00, 4'hF, 2'h0);
        pulse(4'b0010);
        chk_out(0, val_tab[1], val_tab[0]);
        pulse(4'b0001);
        chk_out(0, 8'h00, val_tab[0]);
        // Lane 0 strobe off writes nothing
        wr(addr_tab[2], 8'hBF, 4'hE, 2'h0);
        rd(addr_tab[2], {24'h0, val_tab[2]}, 2'h0);
        // Unmapped places answer with an error and no data
        wr(32'h0000_0084, 8'h11, 4'hF, 2'h2);
        rd(32'h0000_0084, 32'h0, 2'h2);
        rd(32'h0000_0178, 32'h0, 2'h2);
        complete_run();
    end

endmodule : tb_top
